// *** design/biq_pkg.sv ***
// Functional notes
// RULE1: after reset the generation mode defaults to baseband.
// RULE2: baseband path filters, interpolates, scales; I drives channel 0, Q channel 1.
// RULE3: filtering, interpolation and shifting act only while the path is enabled.
// RULE4: real format uses the in-phase path only.
// RULE5: complex format runs each sample pair through both paths.
// RULE6: one sample or one I/Q pair is fetched per input-rate period.
// RULE7: conversion-rate writes are rejected while enabled; rate is derived instead.
// RULE8: frequency shift applies only in baseband mode.
// RULE9: shift rotates I/Q so a downstream modulator output moves in frequency.
// RULE10: real single-channel output carries the shifted signal directly.
// RULE11: filter select offers flat, raised-cosine and root-raised-cosine shapes.
// RULE12: largest interpolation factor is chosen and readable.
// RULE13: factor is 400 MS/s over data rate, truncated to the range step.
// RULE14: software computes data rate as symbol rate times samples per symbol.
// RULE15: software should keep conversion rate between 270 and 400 MS/s.
// RULE16: real interpolation setup order is fixed for software.
// RULE17: complex interpolation setup order is fixed for software.
// RULE18: with external clock, software reads derived rate and programs the clock.
// RULE19: plain playback is done by clearing the path enable.
// RULE20: a new sample is accepted once every overall factor clocks.
// RULE21: zeros are stuffed between samples, then low-pass filtered.
// RULE22: settings are latched at generation start and held until stop.
// RULE23: in real mode the quadrature output is driven with zeros.
package biq_pkg;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int SMP_W = 16;
   localparam int RATE_W = 20;
   localparam int FACT_W = 16;
   localparam int PHASE_W = 16;
   localparam int LUT_W = 4;
   localparam int COS_FRAC = 14;
   localparam int COEF_W = 16;
   localparam int COEF_SHIFT = 6;
   localparam int FIR_TAPS = 4;
   localparam int FT_W = 2;

   localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
   localparam logic [ADDR_W-1:0] OFS_RATE = 8'h04;
   localparam logic [ADDR_W-1:0] OFS_SHIFT = 8'h08;
   localparam logic [ADDR_W-1:0] OFS_CONV = 8'h0C;
   localparam logic [ADDR_W-1:0] OFS_FACTOR = 8'h10;
   localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h14;

   localparam int CTRL_EN_BIT = 0;
   localparam int CTRL_MODE_BIT = 1;
   localparam int CTRL_CPLX_BIT = 2;
   localparam int CTRL_FT_LSB = 3;
   localparam int CTRL_RUN_BIT = 8;
   localparam int STAT_RUN_BIT = 0;
   localparam int STAT_BUSY_BIT = 1;

   // full-scale conversion rate in kS/s
   localparam logic [RATE_W-1:0] CONV_FULL_KSPS = 20'h61A80;
   localparam logic [DATA_W-1:0] CONV_RESET = 32'h00061A80;
   localparam logic [RATE_W-1:0] RATE_RESET = 20'h003E8;
   localparam logic [FACT_W-1:0] FACTOR_RESET = 16'h0190;
   localparam logic [LUT_W-1:0] LUT_QUARTER = 4'h4;

   // interpolation range limits and steps
   localparam logic [RATE_W-1:0] Q_MAX = 20'h08000;
   localparam logic [RATE_W-1:0] Q_STEP32 = 20'h04000;
   localparam logic [RATE_W-1:0] Q_STEP16 = 20'h02000;
   localparam logic [RATE_W-1:0] Q_STEP8 = 20'h00018;
   localparam logic [RATE_W-1:0] Q_STEP4 = 20'h0000C;
   localparam logic [RATE_W-1:0] Q_EIGHT = 20'h00008;
   localparam logic [RATE_W-1:0] Q_FOUR = 20'h00004;
   localparam logic [RATE_W-1:0] Q_TWO = 20'h00002;
   localparam logic [RATE_W-1:0] MASK32 = 20'hFFFE0;
   localparam logic [RATE_W-1:0] MASK16 = 20'hFFFF0;
   localparam logic [RATE_W-1:0] MASK8 = 20'hFFFF8;
   localparam logic [RATE_W-1:0] MASK4 = 20'hFFFFC;

   typedef enum logic {BIQ_MODE_BASEBAND, BIQ_MODE_IF} biq_mode_e;
   typedef enum logic [FT_W-1:0] {BIQ_FLT_FLAT, BIQ_FLT_RC, BIQ_FLT_RRC} biq_filt_e;

   function automatic logic [FACT_W-1:0] biq_round_factor(input logic [RATE_W-1:0] q);
      logic [RATE_W-1:0] r;
      r = 20'h00001;
      if (q >= Q_MAX) r = Q_MAX;
      else if (q >= Q_STEP32) r = q & MASK32;
      else if (q >= Q_STEP16) r = q & MASK16;
      else if (q >= Q_STEP8) r = q & MASK8;
      else if (q >= Q_STEP4) r = q & MASK4;
      else if (q >= Q_EIGHT) r = Q_EIGHT;
      else if (q >= Q_FOUR) r = Q_FOUR;
      else if (q >= Q_TWO) r = Q_TWO;
      return r[FACT_W-1:0];
   endfunction

   // cosine in Q1.14 over sixteen phase steps
   function automatic logic signed [COEF_W-1:0] biq_cos(input logic [LUT_W-1:0] idx);
      logic [LUT_W-1:0] m;
      logic signed [COEF_W-1:0] v;
      m = idx[LUT_W-1] ? (4'h0 - idx) : idx;
      unique case (m[2:0])
         3'h0: v = 16'h4000;
         3'h1: v = 16'h3B21;
         3'h2: v = 16'h2D41;
         3'h3: v = 16'h187E;
         3'h4: v = 16'h0000;
         3'h5: v = 16'hE782;
         3'h6: v = 16'hD2BF;
         3'h7: v = 16'hC4DF;
      endcase
      if (m == 4'h8) v = 16'hC000;
      return v;
   endfunction

   function automatic logic signed [COEF_W-1:0] biq_coef(input logic [FT_W-1:0] ft,
                                                         input int k);
      logic edge_tap;
      edge_tap = (k == 0) || (k == FIR_TAPS - 1);
      if (ft == BIQ_FLT_RC) return edge_tap ? 16'h0004 : 16'h001C;
      if (ft == BIQ_FLT_RRC) return edge_tap ? 16'h0002 : 16'h001E;
      return edge_tap ? 16'h0008 : 16'h0018;
   endfunction
endpackage

// *** design/biq_if.sv ***
`timescale 1ns/100ps
interface biq_div_if;
   logic start;
   logic busy;
   logic done;
   logic [biq_pkg::RATE_W-1:0] dividend;
   logic [biq_pkg::RATE_W-1:0] divisor;
   logic [biq_pkg::RATE_W-1:0] quotient;
   modport ctrl(output start, dividend, divisor, input busy, done, quotient);
   modport unit(input start, dividend, divisor, output busy, done, quotient);
endinterface

interface biq_fir_if;
   logic clear;
   logic [biq_pkg::FT_W-1:0] ftype;
   logic signed [biq_pkg::SMP_W-1:0] in_i;
   logic signed [biq_pkg::SMP_W-1:0] in_q;
   logic signed [biq_pkg::SMP_W-1:0] out_i;
   logic signed [biq_pkg::SMP_W-1:0] out_q;
   modport ctrl(output clear, ftype, in_i, in_q, input out_i, out_q);
   modport unit(input clear, ftype, in_i, in_q, output out_i, out_q);
endinterface

// *** design/biq_divider.sv ***
`timescale 1ns/100ps
module biq_divider
(
   input wire logic clock_i,
   input wire logic nrst_i,
   biq_div_if.unit div
);
   localparam int W = biq_pkg::RATE_W;
   localparam logic [4:0] STEPS = 5'h14;
   logic [W-1:0] rem_q;
   logic [W-1:0] quo_q;
   logic [4:0] cnt_q;
   logic done_q;
   wire [W:0] shifted = {rem_q, quo_q[W-1]};
   wire fits = shifted >= {1'b0, div.divisor};
   wire [W:0] diff = shifted - {1'b0, div.divisor};

   // restoring division, one quotient bit per clock
   always_ff @(posedge clock_i)
   begin
      if (!nrst_i)
      begin
         rem_q <= '0;
         quo_q <= '0;
         cnt_q <= '0;
         done_q <= 1'b0;
      end
      else if (div.start)
      begin
         rem_q <= '0;
         quo_q <= div.dividend;
         cnt_q <= STEPS;
         done_q <= 1'b0;
      end
      else if (cnt_q != '0)
      begin
         rem_q <= fits ? diff[W-1:0] : shifted[W-1:0];
         quo_q <= {quo_q[W-2:0], fits};
         cnt_q <= cnt_q - 5'h01;
         done_q <= (cnt_q == 5'h01);
      end
      else
      begin
         done_q <= 1'b0;
      end
   end

   assign div.busy = (cnt_q != '0);
   assign div.done = done_q;
   assign div.quotient = quo_q;
endmodule

// *** design/biq_fir.sv ***
`timescale 1ns/100ps
module biq_fir #(parameter int TAPS = biq_pkg::FIR_TAPS)
(
   input wire logic clock_i,
   input wire logic nrst_i,
   biq_fir_if.unit fir
);
   localparam int W = biq_pkg::SMP_W;
   localparam int ACC_W = W + biq_pkg::COEF_W + 2;
   logic signed [W-1:0] tap_i [TAPS];
   logic signed [W-1:0] tap_q [TAPS];
   logic signed [ACC_W-1:0] acc_i;
   logic signed [ACC_W-1:0] acc_q;
   logic signed [W-1:0] out_i_q;
   logic signed [W-1:0] out_q_q;

   // delay line: zero-stuffed samples enter at tap 0
   for (genvar k = 0; k < TAPS; k++)
   begin : g_tap
      always_ff @(posedge clock_i)
      begin
         if (!nrst_i || fir.clear)
         begin
            tap_i[k] <= '0;
            tap_q[k] <= '0;
         end
         else
         begin
            tap_i[k] <= (k == 0) ? fir.in_i : tap_i[(k == 0) ? 0 : k - 1];
            tap_q[k] <= (k == 0) ? fir.in_q : tap_q[(k == 0) ? 0 : k - 1];
         end
      end
   end

   always_comb
   begin
      acc_i = '0;
      acc_q = '0;
      for (int k = 0; k < TAPS; k++)
      begin
         acc_i = acc_i + ACC_W'(tap_i[k] * biq_pkg::biq_coef(fir.ftype, k)); // RULE11
         acc_q = acc_q + ACC_W'(tap_q[k] * biq_pkg::biq_coef(fir.ftype, k));
      end
   end

   always_ff @(posedge clock_i)
   begin
      if (!nrst_i || fir.clear)
      begin
         out_i_q <= '0;
         out_q_q <= '0;
      end
      else
      begin
         out_i_q <= W'(acc_i >>> biq_pkg::COEF_SHIFT);
         out_q_q <= W'(acc_q >>> biq_pkg::COEF_SHIFT);
      end
   end

   assign fir.out_i = out_i_q;
   assign fir.out_q = out_q_q;
endmodule

// *** design/biq_interp_ctrl.sv ***
`timescale 1ns/100ps
module biq_interp_ctrl
(
   input wire logic clock_i,
   input wire logic nrst_i,
   input wire logic [biq_pkg::ADDR_W-1:0] reg_addr_i,
   input wire logic [biq_pkg::DATA_W-1:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output logic [biq_pkg::DATA_W-1:0] reg_rdata_o,
   input wire logic signed [biq_pkg::SMP_W-1:0] mem_i_i,
   input wire logic signed [biq_pkg::SMP_W-1:0] mem_q_i,
   input wire logic mem_valid_i,
   output logic mem_ready_o,
   output logic signed [biq_pkg::SMP_W-1:0] dac0_o,
   output logic signed [biq_pkg::SMP_W-1:0] dac1_o
);
   localparam int SW = biq_pkg::SMP_W;
   localparam int FW = biq_pkg::FACT_W;
   localparam int RW = biq_pkg::RATE_W;
   localparam int PW = biq_pkg::PHASE_W;
   localparam int DW = biq_pkg::DATA_W;
   localparam int CW = biq_pkg::COEF_W;
   localparam int PROD_W = SW + CW;

   // software-visible settings
   logic en_q;
   logic cplx_q;
   logic run_q;
   biq_pkg::biq_mode_e mode_q;
   biq_pkg::biq_filt_e ftype_q;
   logic [RW-1:0] rate_q;
   logic [PW-1:0] shift_q;
   logic [DW-1:0] conv_q;
   logic [FW-1:0] factor_q;
   logic start_q;
   logic [DW-1:0] rdata_q;

   // settings in force during generation
   logic act_en_q;
   logic act_cplx_q;
   logic act_bb_q;
   logic [biq_pkg::FT_W-1:0] act_ftype_q;
   logic [FW-1:0] act_factor_q;
   logic [PW-1:0] act_shift_q;

   // datapath state
   logic [FW-1:0] cnt_q;
   logic ready_q;
   logic signed [SW-1:0] smp_i_q;
   logic signed [SW-1:0] smp_q_q;
   logic [PW-1:0] phase_q;
   logic signed [SW-1:0] rot_i_q;
   logic signed [SW-1:0] rot_q_q;
   logic signed [SW-1:0] dac0_q;
   logic signed [SW-1:0] dac1_q;

   biq_div_if div_bus ();
   biq_fir_if fir_bus ();

   // register decode
   wire wr_ctrl = reg_wr_i && (reg_addr_i == biq_pkg::OFS_CTRL);
   wire wr_rate = reg_wr_i && (reg_addr_i == biq_pkg::OFS_RATE);
   wire wr_shift = reg_wr_i && (reg_addr_i == biq_pkg::OFS_SHIFT);
   wire wr_conv = reg_wr_i && (reg_addr_i == biq_pkg::OFS_CONV);
   // settings written together with run must be the ones that latch
   wire run_d = wr_ctrl ? reg_wdata_i[biq_pkg::CTRL_RUN_BIT] : run_q;
   wire en_d = wr_ctrl ? reg_wdata_i[biq_pkg::CTRL_EN_BIT] : en_q;
   wire cplx_d = wr_ctrl ? reg_wdata_i[biq_pkg::CTRL_CPLX_BIT] : cplx_q;
   wire bb_d = (wr_ctrl ? biq_pkg::biq_mode_e'(reg_wdata_i[biq_pkg::CTRL_MODE_BIT]) : mode_q)
      == biq_pkg::BIQ_MODE_BASEBAND;
   wire [biq_pkg::FT_W-1:0] ftype_d =
      wr_ctrl ? reg_wdata_i[biq_pkg::CTRL_FT_LSB +: biq_pkg::FT_W] : ftype_q;
   wire [RW+FW-1:0] derived_full = rate_q * factor_q;
   wire [DW-1:0] derived_conv = derived_full[DW-1:0];
   // enabled path reports the derived conversion rate
   wire [DW-1:0] conv_view = en_q ? derived_conv : conv_q; // RULE7
   wire [DW-1:0] ctrl_view = DW'({run_q, 3'h0, ftype_q, cplx_q, mode_q, en_q});
   wire [DW-1:0] stat_view = DW'({div_bus.busy, run_q});
   wire [DW-1:0] rd_mux =
      (reg_addr_i == biq_pkg::OFS_CTRL) ? ctrl_view :
      (reg_addr_i == biq_pkg::OFS_RATE) ? DW'(rate_q) :
      (reg_addr_i == biq_pkg::OFS_SHIFT) ? DW'(shift_q) :
      (reg_addr_i == biq_pkg::OFS_CONV) ? conv_view :
      (reg_addr_i == biq_pkg::OFS_FACTOR) ? DW'(factor_q) : // RULE12
      (reg_addr_i == biq_pkg::OFS_STATUS) ? stat_view : '0;

   // datapath selection
   wire take = ready_q && mem_valid_i;
   wire cnt_wrap = (cnt_q == '0);
   wire signed [CW-1:0] cos_v = biq_pkg::biq_cos(phase_q[PW-1 -: biq_pkg::LUT_W]);
   wire signed [CW-1:0] sin_v =
      biq_pkg::biq_cos(phase_q[PW-1 -: biq_pkg::LUT_W] - biq_pkg::LUT_QUARTER);
   wire signed [PROD_W-1:0] p_ic = fir_bus.out_i * cos_v;
   wire signed [PROD_W-1:0] p_qs = fir_bus.out_q * sin_v;
   wire signed [PROD_W-1:0] p_is = fir_bus.out_i * sin_v;
   wire signed [PROD_W-1:0] p_qc = fir_bus.out_q * cos_v;
   // rotation by the running phase moves the spectrum by the shift amount
   wire signed [PROD_W-1:0] rot_i_full = (p_ic - p_qs) >>> biq_pkg::COS_FRAC; // RULE9
   wire signed [PROD_W-1:0] rot_q_full = (p_is + p_qc) >>> biq_pkg::COS_FRAC;
   wire signed [SW-1:0] dac0_d = !run_q ? '0 : (act_en_q ? rot_i_q : smp_i_q); // RULE2
   wire signed [SW-1:0] dac1_d =
      (!run_q || !act_cplx_q) ? '0 : (act_en_q ? rot_q_q : smp_q_q); // RULE23

   assign div_bus.start = start_q;
   assign div_bus.dividend = biq_pkg::CONV_FULL_KSPS;
   assign div_bus.divisor = (rate_q == '0) ? RW'(1) : rate_q;
   assign fir_bus.clear = !run_q || !act_en_q; // RULE3
   assign fir_bus.ftype = act_ftype_q;
   assign fir_bus.in_i = smp_i_q; // RULE21
   assign fir_bus.in_q = smp_q_q; // RULE5

   biq_divider u_div
   (
      .clock_i(clock_i),
      .nrst_i(nrst_i),
      .div(div_bus.unit)
   );

   biq_fir u_fir
   (
      .clock_i(clock_i),
      .nrst_i(nrst_i),
      .fir(fir_bus.unit)
   );

   // software registers
   always_ff @(posedge clock_i)
   begin
      if (!nrst_i)
      begin
         en_q <= 1'b0;
         cplx_q <= 1'b0;
         run_q <= 1'b0;
         mode_q <= biq_pkg::BIQ_MODE_BASEBAND; // RULE1
         ftype_q <= biq_pkg::BIQ_FLT_FLAT;
         rate_q <= biq_pkg::RATE_RESET;
         shift_q <= '0;
         conv_q <= biq_pkg::CONV_RESET;
         start_q <= 1'b0;
         rdata_q <= '0;
      end
      else
      begin
         if (wr_ctrl)
         begin
            en_q <= reg_wdata_i[biq_pkg::CTRL_EN_BIT];
            mode_q <= biq_pkg::biq_mode_e'(reg_wdata_i[biq_pkg::CTRL_MODE_BIT]);
            cplx_q <= reg_wdata_i[biq_pkg::CTRL_CPLX_BIT];
            ftype_q <= biq_pkg::biq_filt_e'(reg_wdata_i[biq_pkg::CTRL_FT_LSB +: biq_pkg::FT_W]);
            run_q <= reg_wdata_i[biq_pkg::CTRL_RUN_BIT];
         end
         if (wr_rate)
            rate_q <= reg_wdata_i[RW-1:0];
         if (wr_shift)
            shift_q <= reg_wdata_i[PW-1:0];
         if (wr_conv && !en_q)
            conv_q <= reg_wdata_i; // RULE7
         start_q <= wr_rate;
         rdata_q <= reg_rd_i ? rd_mux : '0;
      end
   end

   // factor readback follows each rate write once the divider finishes
   always_ff @(posedge clock_i)
   begin
      if (!nrst_i)
         factor_q <= biq_pkg::FACTOR_RESET;
      else if (div_bus.done)
         factor_q <= biq_pkg::biq_round_factor(div_bus.quotient); // RULE13
   end

   // settings track software while idle and freeze while running
   always_ff @(posedge clock_i)
   begin
      if (!nrst_i)
      begin
         act_en_q <= 1'b0;
         act_cplx_q <= 1'b0;
         act_bb_q <= 1'b1;
         act_ftype_q <= '0;
         act_factor_q <= biq_pkg::FACTOR_RESET;
         act_shift_q <= '0;
      end
      else if (!run_q)
      begin
         act_en_q <= en_d; // RULE22
         act_cplx_q <= cplx_d;
         act_bb_q <= bb_d;
         act_ftype_q <= ftype_d;
         act_factor_q <= factor_q;
         act_shift_q <= shift_q;
      end
   end

   // input-rate stage: one fetch per overall factor clocks, or one every clock while the path is disabled
   always_ff @(posedge clock_i)
   begin
      if (!nrst_i || !run_q)
      begin
         cnt_q <= '0;
         ready_q <= 1'b0;
      end
      else
      begin
         cnt_q <= cnt_wrap ? act_factor_q - FW'(1) : cnt_q - FW'(1); // RULE20
         // drop ready with the stop write so no sample is taken after run ends
         ready_q <= run_d && (!act_en_q || cnt_wrap); // RULE6
      end
   end

   // sample stage; zeros fill the clocks between fetches
   always_ff @(posedge clock_i)
   begin
      if (!nrst_i || !run_q)
      begin
         smp_i_q <= '0;
         smp_q_q <= '0;
      end
      else
      begin
         smp_i_q <= take ? mem_i_i : '0; // RULE21
         smp_q_q <= (take && act_cplx_q) ? mem_q_i : '0; // RULE4
      end
   end

   // shift oscillator held at zero phase outside baseband
   always_ff @(posedge clock_i)
   begin
      if (!nrst_i || !run_q)
         phase_q <= '0;
      else if (act_en_q && act_bb_q)
         phase_q <= phase_q + act_shift_q; // RULE8
   end

   // wrap on overflow is accepted; gain headroom is the caller's concern
   always_ff @(posedge clock_i)
   begin
      if (!nrst_i || !run_q)
      begin
         rot_i_q <= '0;
         rot_q_q <= '0;
      end
      else
      begin
         rot_i_q <= rot_i_full[SW-1:0]; // RULE10
         rot_q_q <= rot_q_full[SW-1:0];
      end
   end

   always_ff @(posedge clock_i)
   begin
      if (!nrst_i)
      begin
         dac0_q <= '0;
         dac1_q <= '0;
      end
      else
      begin
         dac0_q <= dac0_d;
         dac1_q <= dac1_d;
      end
   end

   assign reg_rdata_o = rdata_q;
   assign mem_ready_o = ready_q;
   assign dac0_o = dac0_q;
   assign dac1_o = dac1_q;

   // checking helpers: clocks since the previous fetch
   logic [FW:0] gap_q;
   logic seen_q;
   always_ff @(posedge clock_i)
   begin
      if (!nrst_i || !run_q)
      begin
         gap_q <= '0;
         seen_q <= 1'b0;
      end
      else
      begin
         gap_q <= ready_q ? (FW+1)'(1) : gap_q + (FW+1)'(1);
         seen_q <= seen_q || ready_q;
      end
   end

   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!nrst_i);

   a_default_mode_bb: // RULE1
      assert property ($rose(nrst_i) |-> mode_q == biq_pkg::BIQ_MODE_BASEBAND)
      else $error("mode is not baseband after reset");

   a_real_q_zero: // RULE23
      assert property ((run_q && !act_cplx_q) |=> (!run_q || dac1_o == '0))
      else $error("quadrature output not zero in real mode");

   a_conv_write_blocked: // RULE7
      assert property ((wr_conv && en_q) |=> $stable(conv_q))
      else $error("conversion rate written while path enabled");

   a_fetch_spacing: // RULE20
      assert property ((ready_q && seen_q && act_en_q) |-> gap_q == (FW+1)'(act_factor_q))
      else $error("fetch spacing differs from overall factor");

   a_shift_bb_only: // RULE8
      assert property ((run_q && !act_bb_q) |-> phase_q == '0)
      else $error("phase advanced outside baseband mode");

   a_bypass_ready_each: // RULE3
      assert property ((run_q && $past(run_q, 2) && !act_en_q) |-> ready_q)
      else $error("bypass path did not fetch every clock");

   a_bypass_route_i: // RULE3
      assert property ((run_q && !act_en_q && take) ##1 run_q |=> dac0_o == $past(mem_i_i, 2))
      else $error("bypass sample did not reach channel 0");

   a_factor_step_ok: // RULE13
      assert property ((factor_q >= FW'(biq_pkg::Q_STEP8) && factor_q < FW'(biq_pkg::Q_STEP16))
                       |-> factor_q[2:0] == 3'h0)
      else $error("factor not on its range step");

   a_settings_held: // RULE22
      assert property ((run_q && $past(run_q)) |-> ($stable(act_factor_q) && $stable(act_en_q)))
      else $error("active settings changed during generation");

   a_rdata_one_cycle: // RULE12
      assert property ((reg_rd_i && reg_addr_i == biq_pkg::OFS_FACTOR)
                       |=> reg_rdata_o == DW'($past(factor_q)))
      else $error("factor readback wrong");
endmodule

// *** tb/biq_mem_model.sv ***
`timescale 1ns/100ps
module biq_mem_model
(
   input wire logic clock_i,
   input wire logic ready_i,
   input wire logic slow_i,
   output logic signed [biq_pkg::SMP_W-1:0] i_o,
   output logic signed [biq_pkg::SMP_W-1:0] q_o,
   output logic valid_o
);
   logic signed [biq_pkg::SMP_W-1:0] d_i = 16'sh0123;
   logic signed [biq_pkg::SMP_W-1:0] d_q = 16'sh0456;
   logic ph = 1'b0;
   initial valid_o = 1'b1;
   // a gap shows inverted data so a stale sample can never match
   assign i_o = valid_o ? d_i : ~d_i;
   assign q_o = valid_o ? d_q : ~d_q;
   always @(posedge clock_i)
   begin
      ph <= ~ph;
      valid_o <= !slow_i || ph;
      if (ready_i && valid_o)
      begin
         d_i <= 16'($urandom);
         d_q <= 16'($urandom);
      end
   end
endmodule

// *** tb/baseband_iq_interpolator_ctrl_bench.sv ***
`timescale 1ns/100ps
module baseband_iq_interpolator_ctrl_bench;
   logic clock_i = 1'b0;
   logic nrst_i = 1'b0;
   logic [7:0] addr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic [31:0] rdata;
   logic wr = 1'b0, rd = 1'b0, slow = 1'b0, ready, valid;
   logic signed [15:0] mi, mq, dac0, dac1;
   int failures = 0, num_checks = 0, gap_exp = 0, cnt = 0, q_nz = 0;
   logic [31:0] rq[$];
   logic [31:0] dq[$];
   logic rd_d = 0, t1 = 0, t2 = 0, byp = 0, real_run = 0, seen = 0;
   int rates[8] = '{12, 20, 45, 4450, 30000, 45000, 150000, 300000};
   int facts[8] = '{32768, 20000, 8880, 88, 12, 8, 2, 1};
   initial forever #25 clock_i = ~clock_i;
   biq_interp_ctrl biq_interp_ctrl_inst (.clock_i(clock_i), .nrst_i(nrst_i),
      .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd),
      .reg_rdata_o(rdata), .mem_i_i(mi), .mem_q_i(mq), .mem_valid_i(valid),
      .mem_ready_o(ready), .dac0_o(dac0), .dac1_o(dac1));
   biq_mem_model biq_mem_model_inst (.clock_i(clock_i), .ready_i(ready), .slow_i(slow),
      .i_o(mi), .q_o(mq), .valid_o(valid));
   task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
      num_checks++;
      if (got !== exp)
      begin
         failures++;
         $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask
   task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
      @(posedge clock_i);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clock_i);
      wr <= 1'b0;
   endtask
   task automatic rd_reg(input logic [7:0] a, input logic [31:0] e);
      rq.push_back(e);
      @(posedge clock_i);
      addr <= a;
      rd <= 1'b1;
      @(posedge clock_i);
      rd <= 1'b0;
   endtask
   function automatic logic [31:0] ctl(logic en, logic md, logic cx, logic [1:0] ft, logic run);
      return {23'h0, run, 3'h0, ft, cx, md, en};
   endfunction
   task automatic stop_test();
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   // results are matched against the oldest note as they appear
   always @(posedge clock_i)
   begin
      rd_d <= rd;
      cnt <= cnt + 1;
      if (rd_d) check(rdata, rq.pop_front(), "read data");
      if (ready && valid)
      begin
         if (gap_exp != 0 && seen) check(cnt, gap_exp, "take spacing");
         seen <= 1'b1;
         cnt <= 1;
         if (byp) dq.push_back(32'(mi));
      end
      t1 <= byp && ready && valid;
      t2 <= t1;
      if (t2) check(32'(dac0), dq.pop_front(), "bypass sample");
      if (real_run) check(32'(dac1), 32'h0, "quadrature idle");
      if (dac1 !== 16'sh0) q_nz <= q_nz + 1;
   end
   initial
   begin
      #2000000;
      failures++;
      stop_test();
   end
   initial
   begin
      void'($urandom(43616));
      repeat (6) @(posedge clock_i);
      nrst_i <= 1'b1;
      rd_reg(biq_pkg::OFS_CTRL, 32'h0);
      rd_reg(biq_pkg::OFS_RATE, 32'h3E8);
      rd_reg(biq_pkg::OFS_CONV, biq_pkg::CONV_RESET);
      rd_reg(biq_pkg::OFS_FACTOR, 32'h190);
      rd_reg(8'h18, 32'h0);
      $display("test defaults done");
      for (int k = 0; k < 8; k++)
      begin
         wr_reg(biq_pkg::OFS_RATE, rates[k]);
         repeat (30) @(posedge clock_i);
         rd_reg(biq_pkg::OFS_FACTOR, facts[k]);
      end
      wr_reg(biq_pkg::OFS_RATE, 32'd100000);
      repeat (30) @(posedge clock_i);
      wr_reg(biq_pkg::OFS_CONV, 32'h1234);
      rd_reg(biq_pkg::OFS_CONV, 32'h1234);
      wr_reg(biq_pkg::OFS_CTRL, ctl(1, 0, 0, 0, 0));
      wr_reg(biq_pkg::OFS_CONV, 32'h5555);
      rd_reg(biq_pkg::OFS_CONV, 32'd400000);
      wr_reg(biq_pkg::OFS_CTRL, 32'h0);
      rd_reg(biq_pkg::OFS_CONV, 32'h1234);
      $display("test rates done");
      byp <= 1'b1;
      real_run <= 1'b1;
      slow <= 1'b1;
      wr_reg(biq_pkg::OFS_CTRL, ctl(0, 0, 0, 0, 1));
      repeat (40) @(posedge clock_i);
      // samples taken at the stop edge are dropped by design, so stop noting first
      byp <= 1'b0;
      wr_reg(biq_pkg::OFS_CTRL, 32'h0);
      repeat (6) @(posedge clock_i);
      slow <= 1'b0;
      check(32'(ready), 32'h0, "stopped ready");
      $display("test bypass done");
      for (int f = 0; f < 3; f++)
      begin
         gap_exp <= (f == 0) ? 4 : 8;
         seen <= 1'b0;
         wr_reg(biq_pkg::OFS_CTRL, ctl(1, 0, 0, 2'(f), 1));
         repeat (20) @(posedge clock_i);
         // factor was latched at start, so the new rate waits for the next run
         if (f == 0) wr_reg(biq_pkg::OFS_RATE, 32'd50000);
         repeat (40) @(posedge clock_i);
         wr_reg(biq_pkg::OFS_CTRL, 32'h0);
         gap_exp <= 0;
         repeat (4) @(posedge clock_i);
      end
      $display("test real interpolation done");
      real_run <= 1'b0;
      q_nz <= 0;
      gap_exp <= 8;
      seen <= 1'b0;
      wr_reg(biq_pkg::OFS_SHIFT, 32'h1000);
      wr_reg(biq_pkg::OFS_CTRL, ctl(1, 0, 1, 0, 1));
      repeat (80) @(posedge clock_i);
      check(32'(q_nz > 0), 32'h1, "quadrature activity");
      wr_reg(biq_pkg::OFS_CTRL, 32'h0);
      gap_exp <= 0;
      repeat (4) @(posedge clock_i);
      $display("test complex done");
      seen <= 1'b0;
      gap_exp <= 8;
      wr_reg(biq_pkg::OFS_CTRL, ctl(1, 1, 1, 0, 1));
      repeat (30) @(posedge clock_i);
      rd_reg(biq_pkg::OFS_STATUS, 32'h1);
      wr_reg(biq_pkg::OFS_CTRL, 32'h0);
      gap_exp <= 0;
      repeat (4) @(posedge clock_i);
      $display("test shift outside baseband done");
      stop_test();
   end
endmodule
